//--- include/pcs_regs.vh
// Purpose: Constants for the PCM codec serial interface.
// Assumes: hclk at 25 MHz; bit clocks well below hclk/4.
// Notes:   Offsets are byte addresses on the AHB-Lite slave.
`ifndef PCS_REGS_VH
`define PCS_REGS_VH
`define PCS_HCLK_MHZ      25
`define PCS_FRAME_US      125
`define PCS_FIXED_HOLD_US 250
`define PCS_OFF_CTRL      8'h00
`define PCS_OFF_STATUS    8'h04
`define PCS_OFF_SLOTS     8'h08
`define PCS_OFF_RXWORD    8'h0C
`define PCS_CTRL_RST      32'h00000000
`define PCS_CTRL_ALAW     0
`define PCS_ST_PDN        0
`define PCS_ST_FIXED      1
`define PCS_ST_RX_SIGNAL_BIT_OUT       2
`define PCS_ST_NFULL      3
`define PCS_ST_TXSIG      4
`define PCS_SL_TX_LSB     0
`define PCS_SL_RX_LSB     8
`define PCS_SLOT_OFF      6'h20
`define PCS_SLOT_FIXED    6'h00
`define PCS_IDLE_CODE     8'hFF
`define PCS_POS_START     9'h000
`define PCS_POS_MAX       9'h1FF
`define PCS_BIT_LAST      3'h7
`define PCS_WORD_BITS     8
`define PCS_FIFO_DEPTH    16
`define PCS_FIFO_AW       4
`define PCS_SYNC_W        8
`define PCS_HOLD_W        16
`endif

//--- src/pcs_codec.v
// Purpose: Digital serial side of a single-channel PCM voice codec with AHB-Lite status.
// Assumes: All link clocks and pins are asynchronous and sampled by hclk.
// Notes:   Transmit samples enter through a 16-word FIFO; received words leave as pulses.
// Summary of operation
// RULE1: Shift receive PCM in during decode slot, MSB first, on receive clock falls.
// RULE2: Drive previous sample's code during encode slot, MSB first, on transmit clock rises.
// RULE3: Take a sample at encode slot end and send it in the next slot.
// RULE4: Open-drain slot strobe pulls low during encode slot, floats otherwise.
// RULE5: Transmit frame sync two or more cycles wide marks a transmit signaling frame.
// RULE6: Receive frame sync two or more cycles wide marks a receive signaling frame.
// RULE7: In transmit signaling frames the last bit carries the signaling input level.
// RULE8: In receive signaling frames latch the last bit; hold until changed or powered down.
// RULE9: Power-down flag is high exactly while in power-down.
// RULE10: Control bits are captured on each falling edge of the control clock.
// RULE11: Eight control clocks may straddle a frame boundary and still form a word.
// RULE12: Control clock held high selects fixed time slot mode.
// RULE13: In fixed mode the control data pin is a power-down level.
// RULE14: Control words assign transmit and receive slots independently, or power down.
// RULE15: Transmit, receive and control clocks are handled independently and asynchronously.
// RULE16: Sequencers work at 1.536, 1.544 and 2.048 MHz bit clocks.
// RULE17: The A-law setting disables signaling insertion and extraction.
// RULE18: A control word acts only when complete, from the next frame on; power-down sets and clears at once.
// RULE19: In power-down the PCM output floats and the slot strobe is released.
//
// Implementation choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "pcs_regs.vh"

module pcs_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         hclk,
  input  wire         hresetn,
  // Data
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_reg;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= {W{1'b0}};
      q        <= {W{1'b0}};
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

module pcs_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             hclk,
  input  wire             hresetn,
  // Fill side
  input  wire             in_valid,
  output reg              in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_reg;
  reg  [AW-1:0]    rd_reg;
  reg  [AW:0]      cnt_reg;
  reg  [AW:0]      cnt_next;
  wire             push;
  wire             pop;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = (cnt_reg != {(AW+1){1'b0}});
  assign out_data  = mem[rd_reg];
  always @* begin
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + {{AW{1'b0}}, 1'b1};
    end else if (pop && !push) begin
      cnt_next = cnt_reg - {{AW{1'b0}}, 1'b1};
    end
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_reg   <= {AW{1'b0}};
      rd_reg   <= {AW{1'b0}};
      cnt_reg  <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_reg <= rd_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      cnt_reg  <= cnt_next;
      in_ready <= (cnt_next < DEPTH[AW:0]);
    end
  end
  always @(posedge hclk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end
endmodule

module pcs_codec #(
  parameter FIXED_HOLD_CYC = `PCS_FIXED_HOLD_US * `PCS_HCLK_MHZ
) (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Transmit link
  input  wire        tx_bit_clock,
  input  wire        tx_frame_sync,
  input  wire        tx_signal_bit_in,
  output reg         pcm_tx_out,
  output reg         pcm_tx_oe,
  output reg         tx_slot_strobe_n_out,
  output reg         tx_slot_strobe_n_oe,
  // Receive link
  input  wire        rx_bit_clock,
  input  wire        rx_frame_sync,
  input  wire        pcm_rx_in,
  output reg         rx_signal_bit_out,
  // Control port
  input  wire        ctrl_shift_clock,
  input  wire        ctrl_serial_in,
  output reg         powered_down_flag,
  // User sample stream
  input  wire        tx_sample_valid,
  output wire        tx_sample_ready,
  input  wire [7:0]  tx_sample,
  output reg         rx_word_valid,
  output reg  [7:0]  rx_word
);
  localparam [31:0] FRAME_FULL = `PCS_FRAME_US * `PCS_HCLK_MHZ;
  localparam [11:0] FRAME_CYC  = FRAME_FULL[11:0];
  localparam [15:0] HOLD_CYC   = FIXED_HOLD_CYC[15:0];
  wire       tclk, tfs, tsig, rclk;
  wire       rfs, rdin, cclk, cdin;
  reg  [2:0] clk_prev_reg;
  pcs_sync #(.W(`PCS_SYNC_W)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({tx_bit_clock, tx_frame_sync, tx_signal_bit_in, rx_bit_clock,
                rx_frame_sync, pcm_rx_in, ctrl_shift_clock, ctrl_serial_in}),
    .q       ({tclk, tfs, tsig, rclk,
                rfs, rdin, cclk, cdin})
  );
  // Edges come from the second stage only, so all three clocks run independently.
  wire txr  = tclk && !clk_prev_reg[2]; // RULE15
  wire txf  = !tclk && clk_prev_reg[2];
  wire rxf  = !rclk && clk_prev_reg[1];
  wire cf   = !cclk && clk_prev_reg[0];
  reg        alaw_reg;
  reg        fixed_reg;
  reg [15:0] hold_reg;
  reg [11:0] idle_reg;
  reg [7:0]  csh_reg;
  reg [2:0]  cbit_reg;
  reg [5:0]  tx_pend_reg, rx_pend_reg;
  reg [5:0]  tx_slot_reg, rx_slot_reg;
  reg [8:0]  tpos_reg, rpos_reg;
  reg        ton_reg, ron_reg;
  reg        tfs_f_reg, rfs_f_reg;
  reg        tsigfr_reg, rsigfr_reg;
  reg [7:0]  tcode_reg;
  reg [6:0]  rsh_reg;
  reg        wr_pend_reg;
  reg [7:0]  wr_addr_reg;
  wire [7:0] fifo_data;
  wire       fifo_valid;
  // Fixed mode always uses slot zero from the frame sync.
  wire [5:0] tx_eff = fixed_reg ? `PCS_SLOT_FIXED : tx_slot_reg;
  wire [5:0] rx_eff = fixed_reg ? `PCS_SLOT_FIXED : rx_slot_reg;
  wire tmatch = ton_reg && !tpos_reg[8] && !tx_eff[5] && (tpos_reg[7:3] == tx_eff[4:0]);
  wire rmatch = ron_reg && !rpos_reg[8] && !rx_eff[5] && (rpos_reg[7:3] == rx_eff[4:0]);
  wire tlast  = (tpos_reg[2:0] == `PCS_BIT_LAST);
  wire rlast  = (rpos_reg[2:0] == `PCS_BIT_LAST);
  wire pop    = txf && tmatch && tlast && fifo_valid && !powered_down_flag;
  wire [7:0] cword = {csh_reg[6:0], cdin};
  pcs_fifo #(.WIDTH(`PCS_WORD_BITS), .DEPTH(`PCS_FIFO_DEPTH), .AW(`PCS_FIFO_AW)) u_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (tx_sample_valid),
    .in_ready  (tx_sample_ready),
    .in_data   (tx_sample),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_data)
  );
  // Control port, mode detection and power-down.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_prev_reg      <= 3'h0;
      fixed_reg         <= 1'b0;
      hold_reg          <= 16'h0000;
      idle_reg          <= 12'h000;
      csh_reg           <= 8'h00;
      cbit_reg          <= 3'h0;
      tx_pend_reg       <= `PCS_SLOT_OFF;
      rx_pend_reg       <= `PCS_SLOT_OFF;
      powered_down_flag <= 1'b0;
    end else begin
      clk_prev_reg <= {tclk, rclk, cclk};
      if (!cclk) begin
        hold_reg  <= 16'h0000;
        fixed_reg <= 1'b0;
      end else if (hold_reg >= HOLD_CYC) begin
        fixed_reg <= 1'b1; // RULE12
      end else begin
        hold_reg <= hold_reg + 16'h0001;
      end
      if (fixed_reg) begin
        powered_down_flag <= cdin; // RULE13 RULE9
        cbit_reg          <= 3'h0;
      end else if (cf) begin
        idle_reg <= 12'h000;
        csh_reg  <= cword; // RULE10
        cbit_reg <= cbit_reg + 3'h1;
        if (cbit_reg == `PCS_BIT_LAST) begin
          // Only a whole word acts; leading bits are the tx and rx selects.
          if (cword[7] && cword[6]) begin
            powered_down_flag <= 1'b1; // RULE14 RULE18 RULE9
          end else begin
            powered_down_flag <= 1'b0;
            if (!cword[7]) begin
              tx_pend_reg <= cword[5:0]; // RULE14
            end
            if (!cword[6]) begin
              rx_pend_reg <= cword[5:0];
            end
          end
        end
      end else if (idle_reg >= FRAME_CYC) begin
        cbit_reg <= 3'h0; // RULE18
      end else begin
        // A frame without edges drops a partial word; a straddling burst is shorter.
        idle_reg <= idle_reg + 12'h001; // RULE11
      end
    end
  end
  // Encoder sequencer.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tpos_reg             <= `PCS_POS_START;
      ton_reg              <= 1'b0;
      tfs_f_reg            <= 1'b0;
      tsigfr_reg           <= 1'b0;
      tx_slot_reg          <= `PCS_SLOT_OFF;
      tcode_reg            <= `PCS_IDLE_CODE;
      pcm_tx_out           <= 1'b0;
      pcm_tx_oe            <= 1'b0;
      tx_slot_strobe_n_out <= 1'b0;
      tx_slot_strobe_n_oe  <= 1'b0;
    end else begin
      tx_slot_strobe_n_out <= 1'b0;
      if (txf) begin
        tfs_f_reg <= tfs;
        // In power-down nothing is popped, so no sample is taken and none is sent twice.
        if (tmatch && tlast && !powered_down_flag) begin
          tcode_reg <= fifo_valid ? fifo_data : `PCS_IDLE_CODE; // RULE3
        end
        if (tfs && !tfs_f_reg) begin
          tpos_reg    <= `PCS_POS_START; // RULE16
          ton_reg     <= 1'b1;
          tsigfr_reg  <= 1'b0;
          tx_slot_reg <= tx_pend_reg; // RULE18
        end else if (ton_reg) begin
          if (tfs && tpos_reg == `PCS_POS_START) begin
            tsigfr_reg <= 1'b1; // RULE5
          end
          if (tpos_reg != `PCS_POS_MAX) begin
            tpos_reg <= tpos_reg + 9'h001;
          end
        end
      end
      if (txr) begin
        if (tmatch && !powered_down_flag) begin
          pcm_tx_oe           <= 1'b1; // RULE2
          tx_slot_strobe_n_oe <= 1'b1; // RULE4
          if (tlast && tsigfr_reg && !alaw_reg) begin
            pcm_tx_out <= tsig; // RULE7 RULE17
          end else begin
            pcm_tx_out <= tcode_reg[`PCS_BIT_LAST - tpos_reg[2:0]];
          end
        end else begin
          pcm_tx_oe           <= 1'b0;
          tx_slot_strobe_n_oe <= 1'b0;
        end
      end else if (powered_down_flag) begin
        pcm_tx_oe           <= 1'b0; // RULE19
        tx_slot_strobe_n_oe <= 1'b0;
      end
    end
  end
  // Decoder sequencer.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rpos_reg          <= `PCS_POS_START;
      ron_reg           <= 1'b0;
      rfs_f_reg         <= 1'b0;
      rsigfr_reg        <= 1'b0;
      rx_slot_reg       <= `PCS_SLOT_OFF;
      rsh_reg           <= 7'h00;
      rx_word           <= 8'h00;
      rx_word_valid     <= 1'b0;
      rx_signal_bit_out <= 1'b0;
    end else begin
      rx_word_valid <= 1'b0;
      if (powered_down_flag) begin
        rx_signal_bit_out <= 1'b0; // RULE8
      end
      if (rxf) begin
        rfs_f_reg <= rfs;
        if (rmatch && !powered_down_flag) begin
          rsh_reg <= {rsh_reg[5:0], rdin}; // RULE1
          if (rlast) begin
            rx_word       <= {rsh_reg, rdin};
            rx_word_valid <= 1'b1;
            if (rsigfr_reg && !alaw_reg) begin
              rx_signal_bit_out <= rdin; // RULE8 RULE17
            end
          end
        end
        if (rfs && !rfs_f_reg) begin
          rpos_reg    <= `PCS_POS_START;
          ron_reg     <= 1'b1;
          rsigfr_reg  <= 1'b0;
          rx_slot_reg <= rx_pend_reg; // RULE18
        end else if (ron_reg) begin
          if (rfs && rpos_reg == `PCS_POS_START) begin
            rsigfr_reg <= 1'b1; // RULE6
          end
          if (rpos_reg != `PCS_POS_MAX) begin
            rpos_reg <= rpos_reg + 9'h001;
          end
        end
      end
    end
  end
  // AHB-Lite slave: zero wait states, read data registered in the address phase.
  wire acc = hsel && htrans[1] && hready;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata      <= 32'h00000000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      alaw_reg    <= 1'b0;
    end else begin
      wr_pend_reg <= acc && hwrite;
      wr_addr_reg <= haddr[7:0];
      if (wr_pend_reg && wr_addr_reg == `PCS_OFF_CTRL) begin
        alaw_reg <= hwdata[`PCS_CTRL_ALAW];
      end
      if (acc && !hwrite) begin
        case (haddr[7:0])
          `PCS_OFF_CTRL: begin
            hrdata <= `PCS_CTRL_RST | {31'h0, alaw_reg};
          end
          `PCS_OFF_STATUS: begin
            hrdata <= {27'h0, tsigfr_reg, tx_sample_ready, rx_signal_bit_out,
                       fixed_reg, powered_down_flag};
          end
          `PCS_OFF_SLOTS: begin
            hrdata <= {18'h0, rx_slot_reg, 2'h0, tx_slot_reg};
          end
          `PCS_OFF_RXWORD: begin
            hrdata <= {24'h0, rx_word};
          end
          default: begin
            hrdata <= 32'h00000000;
          end
        endcase
      end
    end
  end
endmodule

//--- tb/pcs_codec_chk.sv
// Purpose: Port assertions for the PCM codec serial interface.
// Assumes: Bound to every pcs_codec instance.
// Notes:   Link bit timing is judged by the bench, which knows the frames.
`timescale 1ns/1ps
module pcs_codec_chk (
  // Clock and reset
  input wire        hclk,
  input wire        hresetn,
  // Bus
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  // Link
  input wire        pcm_tx_oe,
  input wire        tx_slot_strobe_n_out,
  input wire        tx_slot_strobe_n_oe,
  input wire        rx_signal_bit_out,
  input wire        powered_down_flag,
  input wire        rx_word_valid
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_bus_ready: assert property (hreadyout && !hresp)
    else $error("bus not ready or error response");
  chk_read_data_cause: assert property
    ($changed(hrdata) |-> $past(hsel && htrans[1] && !hwrite && hready))
    else $error("read data moved without a read");
  chk_strobe_tracks: assert property (tx_slot_strobe_n_oe == pcm_tx_oe)
    else $error("slot strobe differs from data enable");
  chk_strobe_low: assert property (tx_slot_strobe_n_oe |-> !tx_slot_strobe_n_out)
    else $error("slot strobe driven high");
  chk_pdn_float: assert property (powered_down_flag |=> !pcm_tx_oe)
    else $error("data driven in power-down");
  chk_pdn_clears_sig: assert property ($rose(powered_down_flag) |-> ##[0:3] !rx_signal_bit_out)
    else $error("signaling bit not cleared");
  chk_pdn_sig_low: assert property (powered_down_flag [*5] |-> !rx_signal_bit_out)
    else $error("signaling bit set in power-down");
  chk_word_spacing: assert property (rx_word_valid |=> !rx_word_valid [*8])
    else $error("received words too close");
  chk_pdn_no_word: assert property (rx_word_valid |-> !powered_down_flag)
    else $error("word received in power-down");
endmodule
bind pcs_codec pcs_codec_chk i_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .pcm_tx_oe(pcm_tx_oe), .tx_slot_strobe_n_out(tx_slot_strobe_n_out),
  .tx_slot_strobe_n_oe(tx_slot_strobe_n_oe), .rx_signal_bit_out(rx_signal_bit_out),
  .powered_down_flag(powered_down_flag), .rx_word_valid(rx_word_valid)
);

//--- tb/pcs_highway.sv
// Purpose: PCM highway model: bit clock, frame sync, receive data, transmit capture.
// Assumes: Frames are started just after an hclk edge.
// Notes:   The bit clock stands high between frames; both directions share it.
`timescale 1ns/1ps
module pcs_highway (
  // Clock
  input  wire hclk,
  // Highway
  output reg  bit_clock,
  output reg  frame_sync,
  output reg  pcm_rx_in,
  input  wire pcm_tx_out,
  input  wire pcm_tx_oe
);
  initial begin
    bit_clock = 1'b1;
    frame_sync = 1'b0;
    pcm_rx_in = 1'b0;
  end
  // Slot bits stand at falls 8N+1 to 8N+8; elsewhere the line toggles, so a stale bit cannot pass.
  function nb(input integer p, input [4:0] rs, input [7:0] rb, input last);
    nb = (p > 8 * rs && p <= 8 * rs + 8) ? rb[8 * rs + 8 - p] : ~last;
  endfunction
  task frame(input [5:0] ts, input [4:0] rs, input sg, input [7:0] rb,
             output [7:0] tb, output integer bad);
    integer p;
    begin
      bad = 0;
      tb = 8'h00;
      frame_sync <= 1'b1;
      pcm_rx_in <= nb(0, rs, rb, pcm_rx_in);
      for (p = 0; p < 33; p = p + 1) begin
        repeat (4) @(posedge hclk);
        bit_clock <= 1'b0;
        repeat (4) @(posedge hclk);
        if (pcm_tx_oe !== (p > 8 * ts && p <= 8 * ts + 8))
          bad = bad + 1;
        if (p > 8 * ts && p <= 8 * ts + 8)
          tb = {tb[6:0], pcm_tx_out};
        bit_clock <= 1'b1;
        frame_sync <= (p == 0) && sg;
        pcm_rx_in <= nb(p + 1, rs, rb, pcm_rx_in);
      end
      @(posedge hclk);
    end
  endtask
endmodule

//--- tb/pcs_codec_test.sv
// Purpose: Self-checking bench for the PCM codec serial interface.
// Assumes: Bus, control and frame tasks start just after an hclk edge.
// Notes:   Both bit clocks come from one model, so clock skew is not exercised.
`timescale 1ns/1ps
`include "pcs_regs.vh"
module pcs_codec_test;
  reg         hclk;
  reg         hresetn;
  reg         hsel;
  reg  [31:0] haddr;
  reg  [1:0]  htrans;
  reg         hwrite;
  reg  [31:0] hwdata;
  reg         tx_signal_bit_in;
  reg         ctrl_shift_clock;
  reg         ctrl_serial_in;
  reg         tx_sample_valid;
  reg  [7:0]  tx_sample;
  wire [31:0] hrdata;
  wire        hreadyout;
  wire        bclk;
  wire        fsync;
  wire        pcm_rx_in;
  wire        pcm_tx_out;
  wire        pcm_tx_oe;
  wire        rx_signal_bit_out;
  wire        powered_down_flag;
  wire        tx_sample_ready;
  wire [7:0]  rxw;
  integer     n_mismatch;
  integer     compares;
  integer     bad;
  integer     i;
  reg  [31:0] rd;
  reg  [7:0]  txb;
  pcs_codec #(.FIXED_HOLD_CYC(40)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .tx_bit_clock(bclk),
    .tx_frame_sync(fsync), .tx_signal_bit_in(tx_signal_bit_in),
    .pcm_tx_out(pcm_tx_out), .pcm_tx_oe(pcm_tx_oe), .tx_slot_strobe_n_out(),
    .tx_slot_strobe_n_oe(), .rx_bit_clock(bclk), .rx_frame_sync(fsync),
    .pcm_rx_in(pcm_rx_in), .rx_signal_bit_out(rx_signal_bit_out),
    .ctrl_shift_clock(ctrl_shift_clock), .ctrl_serial_in(ctrl_serial_in),
    .powered_down_flag(powered_down_flag), .tx_sample_valid(tx_sample_valid),
    .tx_sample_ready(tx_sample_ready), .tx_sample(tx_sample), .rx_word_valid(),
    .rx_word(rxw)
  );
  pcs_highway i_hw (
    .hclk(hclk), .bit_clock(bclk), .frame_sync(fsync), .pcm_rx_in(pcm_rx_in),
    .pcm_tx_out(pcm_tx_out), .pcm_tx_oe(pcm_tx_oe)
  );
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task results;
    begin
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task check(input [8*10:1] name, input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task ahb(input wr, input [7:0] a, input [31:0] wd, output [31:0] d);
    integer w;
    begin
      w = 0;
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && w < 20) begin
        @(posedge hclk);
        w = w + 1;
      end
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && w < 20) begin
        @(posedge hclk);
        w = w + 1;
      end
      d = hrdata;
      if (w >= 20) begin
        n_mismatch = n_mismatch + 1;
        results;
      end
    end
  endtask
  // Polls a bounded number of times, since flags cross from slow link clocks.
  task reg_is(input [7:0] a, input [31:0] m, input [31:0] e);
    integer k;
    begin
      ahb(1'b0, a, 32'h0, rd);
      for (k = 0; k < 40 && (rd & m) !== e; k = k + 1)
        ahb(1'b0, a, 32'h0, rd);
      check("register", rd & m, e);
    end
  endtask
  task ctrl(input [7:0] w);
    integer k;
    begin
      for (k = 7; k >= 0; k = k - 1) begin
        ctrl_serial_in <= w[k];
        ctrl_shift_clock <= 1'b1;
        repeat (4) @(posedge hclk);
        ctrl_shift_clock <= 1'b0;
        repeat (4) @(posedge hclk);
      end
    end
  endtask
  task frm(input [5:0] ts, input [4:0] rs, input sg, input [7:0] rb, input [7:0] e);
    begin
      i_hw.frame(ts, rs, sg, rb, txb, bad);
      check("tx enable", bad, 0);
      if (ts != 6'h20)
        check("tx code", txb, e);
    end
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    tx_signal_bit_in = 1'b0;
    ctrl_shift_clock = 1'b0;
    ctrl_serial_in = 1'b0;
    tx_sample_valid = 1'b0;
    tx_sample = 8'h00;
    n_mismatch = 0;
    compares = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    tx_sample_valid <= 1'b1;
    tx_sample <= 8'hA0;
    rd = 0;
    for (i = 0; i < 24; i = i + 1) begin
      @(posedge hclk);
      if (tx_sample_ready === 1'b1) begin
        rd = rd + 1;
        tx_sample <= 8'hA0 + rd[7:0];
      end
    end
    tx_sample_valid <= 1'b0;
    check("fifo words", rd, 16);
    reg_is(`PCS_OFF_STATUS, 32'hFFFFFFFF, 32'h0);
    reg_is(`PCS_OFF_CTRL, 32'hFFFFFFFF, `PCS_CTRL_RST);
    reg_is(`PCS_OFF_SLOTS, 32'hFFFFFFFF, 32'h00002020);
    ahb(1'b1, `PCS_OFF_STATUS, 32'hFFFFFFFF, rd);
    ahb(1'b1, 8'h10, 32'hFFFFFFFF, rd);
    reg_is(8'h10, 32'hFFFFFFFF, 32'h0);
    reg_is(`PCS_OFF_STATUS, 32'hFFFFFFFF, 32'h0);
    ctrl(8'h41);
    ctrl(8'h82);
    frm(6'h01, 5'h02, 1'b0, 8'h96, 8'hFF);
    reg_is(`PCS_OFF_SLOTS, 32'hFFFFFFFF, 32'h00000201);
    reg_is(`PCS_OFF_RXWORD, 32'hFF, 32'h96);
    check("rx word", rxw, 8'h96);
    tx_signal_bit_in <= 1'b1;
    frm(6'h01, 5'h02, 1'b1, 8'h81, 8'hA1);
    check("sig out", rx_signal_bit_out, 1'b1);
    tx_signal_bit_in <= 1'b0;
    frm(6'h01, 5'h02, 1'b0, 8'h40, 8'hA1);
    check("sig hold", rx_signal_bit_out, 1'b1);
    ahb(1'b1, `PCS_OFF_CTRL, 32'h1, rd);
    reg_is(`PCS_OFF_CTRL, 32'hFFFFFFFF, 32'h1);
    tx_signal_bit_in <= 1'b1;
    frm(6'h01, 5'h02, 1'b1, 8'h00, 8'hA2);
    check("alaw sig", rx_signal_bit_out, 1'b1);
    reg_is(`PCS_OFF_RXWORD, 32'hFF, 32'h0);
    ahb(1'b1, `PCS_OFF_CTRL, 32'h0, rd);
    ctrl(8'hC0);
    reg_is(`PCS_OFF_STATUS, 32'hF, 32'h9);
    fork
      frm(6'h20, 5'h02, 1'b0, 8'h3C, 8'h00);
      begin
        repeat (240) @(posedge hclk);
        ctrl(8'h41);
      end
    join
    reg_is(`PCS_OFF_STATUS, 32'h1, 32'h0);
    reg_is(`PCS_OFF_RXWORD, 32'hFF, 32'h0);
    ctrl_serial_in <= 1'b0;
    ctrl_shift_clock <= 1'b1;
    reg_is(`PCS_OFF_STATUS, 32'h3, 32'h2);
    frm(6'h00, 5'h00, 1'b0, 8'h5A, 8'hA3);
    reg_is(`PCS_OFF_RXWORD, 32'hFF, 32'h5A);
    ctrl_serial_in <= 1'b1;
    reg_is(`PCS_OFF_STATUS, 32'h3, 32'h3);
    check("pdn flag", powered_down_flag, 1'b1);
    results;
  end
endmodule
